// [shared/srm_pkg.sv]
// Purpose: constants and types for the two-wire register access master
// Assumes: 10 MHz system clock, open-drain bus with external pull-ups
// Notes: target address and framing figures shared by the design files
package srm_pkg;
    // target addressing
    localparam logic [6:0] TARGET_ADDR = 7'h2c;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] LAST_BIT = 4'h7;
    // bus timing: quarter period of the serial clock
    localparam int CLK_HZ = 10000000;
    localparam int SCL_HZ = 100000;
    localparam int QUARTER_CYC = CLK_HZ / (SCL_HZ * 4);
    localparam logic [7:0] QUARTER_CNT = 8'(QUARTER_CYC - 1);
    // bus free time after stop, in quarter periods
    localparam logic [2:0] FREE_QUARTERS = 3'h4;
    // fifo
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    // command codes
    localparam logic CMD_WRITE = 1'b0;
    localparam logic CMD_READ = 1'b1;

    typedef enum logic [3:0] {
        SRM_IDLE, SRM_START, SRM_BIT_LOW, SRM_BIT_HIGH, SRM_BIT_END,
        SRM_ACK_LOW, SRM_ACK_HIGH, SRM_ACK_END, SRM_RSTART, SRM_STOP_LOW,
        SRM_STOP_HIGH, SRM_STOP_END, SRM_FREE
    } srm_state_t;

    typedef enum logic [1:0] {
        SRM_PH_ADDR, SRM_PH_PTR, SRM_PH_WDATA, SRM_PH_RDATA
    } srm_phase_t;
endpackage

// [design/srm_fifo.sv]
// Purpose: small synchronous fifo with valid and ready on both sides
// Assumes: single clock, active-low synchronous-released reset
// Notes: storage is flip-flops addressed by index
`timescale 1ns/100ps
module srm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    // storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    a_fifo_never_over: assert property (@(posedge clk) disable iff (!rst_n)
        count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// [design/srm_master.sv]
// Purpose: two-wire bus master that writes and reads target registers
// Assumes: open-drain scl and sda, pull-ups outside, clk at 10 MHz
// Notes: write data enters through a fifo, read data leaves by a pulse
`timescale 1ns/100ps
module srm_master (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire logic cmd_rw,
    input wire logic [7:0] cmd_ptr,
    input wire logic [4:0] cmd_len,
    output logic cmd_ready,
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic nack_err,
    output logic busy,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    logic rst_s1;
    logic rst_s;
    logic sda_s1;
    logic sda_s;
    logic scl_s1;
    logic scl_s;
    logic [7:0] qcnt;
    logic tick;
    srm_pkg::srm_state_t state;
    srm_pkg::srm_phase_t phase;
    logic [7:0] shreg;
    logic [3:0] bitn;
    logic rw;
    logic [7:0] ptr;
    logic [4:0] left;
    logic addr_sent_read;
    logic [2:0] free_cnt;
    logic sda_low;
    logic scl_low;
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s <= rst_s1;
        end
    end

    // line inputs pass two flops
    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            sda_s1 <= 1'b1;
            sda_s <= 1'b1;
            scl_s1 <= 1'b1;
            scl_s <= 1'b1;
        end else if (ce) begin
            sda_s1 <= sda_in;
            sda_s <= sda_s1;
            scl_s1 <= scl_in;
            scl_s <= scl_s1;
        end
    end

    srm_fifo #(.WIDTH(srm_pkg::FIFO_WIDTH), .DEPTH(srm_pkg::FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_s),
        .ce(ce),
        .in_data(wr_data),
        .in_valid(wr_valid),
        .in_ready(wr_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // quarter period ticks; stretched in SRM_BIT_HIGH while a target holds clock low
    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            qcnt <= 8'h00;
        end else if (ce) begin
            if (tick) begin
                qcnt <= 8'h00;
            end else if (!(state == srm_pkg::SRM_BIT_HIGH && !scl_low && !scl_s)) begin
                qcnt <= qcnt + 8'h01;
            end
        end
    end
    assign tick = (qcnt == srm_pkg::QUARTER_CNT);
    // pop exactly when a write data byte is loaded into the shifter
    assign fifo_pop = ce && tick && state == srm_pkg::SRM_ACK_END && !nack_err &&
        ((phase == srm_pkg::SRM_PH_PTR && rw == srm_pkg::CMD_WRITE) ||
        (phase == srm_pkg::SRM_PH_WDATA && left != 5'h01));

    // main sequencer: framing, bits, acknowledge slots
    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            state <= srm_pkg::SRM_IDLE;
            phase <= srm_pkg::SRM_PH_ADDR;
            shreg <= 8'h00;
            bitn <= 4'h0;
            rw <= srm_pkg::CMD_WRITE;
            ptr <= 8'h00;
            left <= 5'h00;
            addr_sent_read <= 1'b0;
            free_cnt <= 3'h0;
            sda_low <= 1'b0;
            scl_low <= 1'b0;
            cmd_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            nack_err <= 1'b0;
            busy <= 1'b0;
        end else if (ce) begin
            rd_valid <= 1'b0;
            cmd_ready <= (state == srm_pkg::SRM_IDLE) && !cmd_valid;
            case (state)
                srm_pkg::SRM_IDLE: begin
                    sda_low <= 1'b0;
                    scl_low <= 1'b0;
                    if (cmd_valid && cmd_ready && cmd_len != 5'h00 &&
                            (cmd_rw || fifo_valid)) begin
                        rw <= cmd_rw;
                        ptr <= cmd_ptr;
                        left <= cmd_len;
                        nack_err <= 1'b0;
                        addr_sent_read <= 1'b0;
                        busy <= 1'b1;
                        state <= srm_pkg::SRM_START;
                    end
                end
                srm_pkg::SRM_START, srm_pkg::SRM_RSTART: if (tick) begin
                    // start condition
                    // sda falls while clock stays high, then clock goes low
                    // repeated start: clock is released first with sda high
                    if (scl_low) begin
                        scl_low <= 1'b0;
                    end else if (!sda_low) begin
                        sda_low <= 1'b1;
                    end else begin
                        scl_low <= 1'b1;
                        phase <= srm_pkg::SRM_PH_ADDR;
                        shreg <= {srm_pkg::TARGET_ADDR, addr_sent_read};
                        bitn <= 4'h0;
                        state <= srm_pkg::SRM_BIT_LOW;
                    end
                end
                srm_pkg::SRM_BIT_LOW: if (tick) begin
                    sda_low <= (phase == srm_pkg::SRM_PH_RDATA) ? 1'b0 : !shreg[7];
                    state <= srm_pkg::SRM_BIT_HIGH;
                end
                srm_pkg::SRM_BIT_HIGH: if (tick) begin
                    if (!scl_low) begin
                        if (scl_s) begin
                            shreg <= {shreg[6:0], sda_s};
                            state <= srm_pkg::SRM_BIT_END;
                        end
                    end else begin
                        scl_low <= 1'b0;
                    end
                end
                srm_pkg::SRM_BIT_END: if (tick) begin
                    scl_low <= 1'b1;
                    if (bitn == srm_pkg::LAST_BIT) begin
                        state <= srm_pkg::SRM_ACK_LOW;
                    end else begin
                        bitn <= bitn + 4'h1;
                        state <= srm_pkg::SRM_BIT_LOW;
                    end
                end
                srm_pkg::SRM_ACK_LOW: if (tick) begin
                    // nack on the final read byte
                    sda_low <= (phase == srm_pkg::SRM_PH_RDATA) && (left != 5'h01);
                    if (phase == srm_pkg::SRM_PH_RDATA) begin
                        rd_data <= shreg;
                        rd_valid <= 1'b1;
                    end
                    state <= srm_pkg::SRM_ACK_HIGH;
                end
                srm_pkg::SRM_ACK_HIGH: if (tick) begin
                    if (scl_low) begin
                        scl_low <= 1'b0;
                    end else if (scl_s) begin
                        // target silence on mismatch shows as nack
                        if (phase != srm_pkg::SRM_PH_RDATA && sda_s) begin
                            nack_err <= 1'b1;
                        end
                        state <= srm_pkg::SRM_ACK_END;
                    end
                end
                srm_pkg::SRM_ACK_END: if (tick) begin
                    scl_low <= 1'b1;
                    bitn <= 4'h0;
                    state <= srm_pkg::SRM_BIT_LOW;
                    if (nack_err) begin
                        state <= srm_pkg::SRM_STOP_LOW;
                    end else begin
                        case (phase)
                            srm_pkg::SRM_PH_ADDR: begin
                                if (addr_sent_read) begin
                                    phase <= srm_pkg::SRM_PH_RDATA;
                                end else begin
                                    phase <= srm_pkg::SRM_PH_PTR;
                                    shreg <= ptr;
                                end
                            end
                            srm_pkg::SRM_PH_PTR: begin
                                if (rw == srm_pkg::CMD_READ) begin
                                    addr_sent_read <= 1'b1;
                                    sda_low <= 1'b0;
                                    state <= srm_pkg::SRM_RSTART;
                                end else begin
                                    phase <= srm_pkg::SRM_PH_WDATA;
                                    shreg <= fifo_data;
                                end
                            end
                            default: begin
                                left <= left - 5'h01;
                                ptr <= ptr + 8'h01;
                                if (left == 5'h01) begin
                                    state <= srm_pkg::SRM_STOP_LOW;
                                end else if (phase == srm_pkg::SRM_PH_WDATA) begin
                                    shreg <= fifo_data;
                                end
                            end
                        endcase
                    end
                end
                srm_pkg::SRM_STOP_LOW: if (tick) begin
                    sda_low <= 1'b1;
                    state <= srm_pkg::SRM_STOP_HIGH;
                end
                srm_pkg::SRM_STOP_HIGH: if (tick) begin
                    scl_low <= 1'b0;
                    state <= srm_pkg::SRM_STOP_END;
                end
                srm_pkg::SRM_STOP_END: if (tick && scl_s) begin
                    // stop: sda rises with clock high
                    sda_low <= 1'b0;
                    free_cnt <= 3'h0;
                    state <= srm_pkg::SRM_FREE;
                end
                srm_pkg::SRM_FREE: if (tick) begin
                    if (free_cnt == srm_pkg::FREE_QUARTERS) begin
                        busy <= 1'b0;
                        state <= srm_pkg::SRM_IDLE;
                    end else begin
                        free_cnt <= free_cnt + 3'h1;
                    end
                end
                default: state <= srm_pkg::SRM_IDLE;
            endcase
        end
    end

    // open-drain drive of both lines, only ever pulled low
    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else if (ce) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe <= scl_low;
            sda_oe <= sda_low;
        end
    end

    a_sda_stable_high: assert property (@(posedge clk) disable iff (!rst_s)
        (state == srm_pkg::SRM_BIT_HIGH && !scl_low && $past(ce)) |-> $stable(sda_low))
        else $error("sda moved during clock high");
    a_final_nack: assert property (@(posedge clk) disable iff (!rst_s)
        (state == srm_pkg::SRM_ACK_HIGH && phase == srm_pkg::SRM_PH_RDATA && left == 5'h01)
        |-> !sda_low) else $error("final read byte acknowledged");
    // lines are only ever pulled low, never driven high
    a_lines_only_low: assert property (@(posedge clk) disable iff (!rst_s)
        (scl_oe || sda_oe) |-> (!scl_out && !sda_out)) else $error("line driven high");
    // bit counter stays inside one byte
    a_bit_count_range: assert property (@(posedge clk) disable iff (!rst_s)
        bitn <= srm_pkg::LAST_BIT) else $error("bit counter beyond byte");
    a_busy_span: assert property (@(posedge clk) disable iff (!rst_s)
        (state != srm_pkg::SRM_IDLE && $past(state) != srm_pkg::SRM_IDLE) |-> busy)
        else $error("busy dropped mid transaction");
endmodule

// [sim/srm_target_model.sv]
// Purpose: behavioural register target that answers the two-wire master
// Assumes: lines already resolved to wire levels, open-drain with pull-ups
// Notes: own_addr lets the bench make the target ignore its bus address
`timescale 1ns/100ps
module srm_target_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic [6:0] own_addr,
    output logic sda_low
);
    logic [2:0] scl_s, sda_s;
    logic active, tx, mack;
    logic [3:0] bitn;
    logic [1:0] phase;
    logic [7:0] sh, txb, ptr;
    logic [7:0] mem [256];
    logic start, stop, rise, fall;

    // sync and edges: lines resampled in the local clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], scl};
            sda_s <= {sda_s[1:0], sda};
        end
    end
    // conditions: data edges with clock high are start or stop
    assign start = scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1];
    assign stop = scl_s[1] && scl_s[2] && !sda_s[2] && sda_s[1];
    assign rise = scl_s[1] && !scl_s[2];
    assign fall = !scl_s[1] && scl_s[2];

    // byte engine: target only, never touches the clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
            tx <= 1'b0;
            mack <= 1'b0;
            bitn <= 4'h0;
            phase <= 2'h0;
            sh <= 8'h00;
            txb <= 8'h00;
            ptr <= 8'h00;
            sda_low <= 1'b0;
            for (int i = 0; i < 256; i++) mem[i] <= 8'h00;
        end else if (start) begin
            // restart: any start drops the old transfer
            active <= 1'b1;
            tx <= 1'b0;
            // marker: the clock fall that ends the start is not a bit
            bitn <= 4'hf;
            phase <= 2'h0;
            sda_low <= 1'b0;
        end else if (stop) begin
            active <= 1'b0;
            tx <= 1'b0;
            sda_low <= 1'b0;
        end else if (active && rise) begin
            // sampling: msb first, ninth bit is master's answer
            if (bitn < 4'h8) sh <= {sh[6:0], sda_s[1]};
            else mack <= !sda_s[1];
        end else if (active && fall) begin
            if (bitn == 4'hf) begin
                bitn <= 4'h0;
            end else if (bitn < 4'h7) begin
                bitn <= bitn + 4'h1;
                sda_low <= tx && !txb[3'(6 - bitn)];
            end else if (bitn == 4'h7) begin
                bitn <= 4'h8;
                // release: transmitter lets go in the ack slot
                sda_low <= !tx;
                if (!tx) begin
                    case (phase)
                        2'h0: if (sh[7:1] != own_addr) begin
                            active <= 1'b0;
                            sda_low <= 1'b0;
                        end
                        2'h1: ptr <= sh;
                        default: begin
                            mem[ptr] <= sh;
                            ptr <= ptr + 8'h01;
                        end
                    endcase
                end
            end else begin
                bitn <= 4'h0;
                sda_low <= 1'b0;
                if (tx) begin
                    // next byte on ack, end of data on nack
                    if (mack) begin
                        ptr <= ptr + 8'h01;
                        txb <= mem[8'(ptr + 8'h01)];
                        sda_low <= !mem[8'(ptr + 8'h01)][7];
                    end else begin
                        active <= 1'b0;
                        tx <= 1'b0;
                    end
                end else if (phase == 2'h0) begin
                    // direction: a one turns the target to sending
                    phase <= sh[0] ? 2'h3 : 2'h1;
                    if (sh[0]) begin
                        tx <= 1'b1;
                        txb <= mem[ptr];
                        sda_low <= !mem[ptr][7];
                    end
                end else if (phase == 2'h1) begin
                    phase <= 2'h2;
                end
            end
        end
    end
endmodule

// [sim/test_srm_master.sv]
// Purpose: self-checking bench for the two-wire register master
// Assumes: target model on the far side, pull-ups on both lines
// Notes: row table covers plain transfers; fifo fill and nack follow it
`timescale 1ns/100ps
module test_srm_master;
    typedef struct {logic rw; logic [7:0] ptr; logic [4:0] len; logic [7:0] base;} srm_row_t;
    logic clk, rst_n, ce, cmd_valid, cmd_rw, cmd_ready, wr_valid, wr_ready;
    logic rd_valid, nack_err, busy, scl_out, scl_oe, sda_out, sda_oe, tgt_low, saw_nack;
    logic [7:0] cmd_ptr, wr_data, rd_data;
    logic [4:0] cmd_len;
    logic [6:0] own_addr;
    wire logic scl_w;
    wire logic sda_w;
    int n_fail, checks_done, n_start, n_stop, n, k;
    logic [7:0] rd_q[$];
    srm_row_t rows[6] = '{'{1'b0, 8'h10, 5'h03, 8'ha5}, '{1'b1, 8'h10, 5'h03, 8'ha5},
        '{1'b0, 8'hfe, 5'h02, 8'h3c}, '{1'b1, 8'hfe, 5'h02, 8'h3c},
        '{1'b0, 8'h00, 5'h01, 8'h81}, '{1'b1, 8'h00, 5'h01, 8'h81}};

    // open-drain wires: low when any party pulls, else pulled up
    assign scl_w = !(scl_oe && !scl_out);
    assign sda_w = !(sda_oe && !sda_out) && !tgt_low;

    srm_master uut (.clk(clk), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid),
        .cmd_rw(cmd_rw), .cmd_ptr(cmd_ptr), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
        .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .nack_err(nack_err), .busy(busy), .scl_in(scl_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe));
    srm_target_model u_tgt (.clk(clk), .rst_n(rst_n), .scl(scl_w), .sda(sda_w),
        .own_addr(own_addr), .sda_low(tgt_low));

    initial begin
        clk = 1'b0;
        forever #50 clk = !clk;
    end
    // wire monitor: count start and stop conditions
    always @(negedge sda_w) if (scl_w === 1'b1) n_start++;
    always @(posedge sda_w) if (scl_w === 1'b1) n_stop++;
    // read data and nack collection
    always @(posedge clk) begin
        if (rd_valid === 1'b1) rd_q.push_back(rd_data);
        if (nack_err === 1'b1) saw_nack = 1'b1;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic timed_out(input string msg);
        n_fail++;
        $display("wrong value at %0t: timeout %s", $time, msg);
        report_and_stop();
    endtask
    // push one word, refusal after four cycles returns zero
    task automatic push(input logic [7:0] d, output logic ok);
        @(posedge clk);
        wr_data <= d;
        wr_valid <= 1'b1;
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            ok = (wr_ready === 1'b1);
        end
        wr_valid <= 1'b0;
    endtask
    task automatic do_cmd(input logic rw, input logic [7:0] ptr, input logic [4:0] len);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_rw <= rw;
        cmd_ptr <= ptr;
        cmd_len <= len;
        for (n = 0; n < 1000; n++) begin
            @(posedge clk);
            if (cmd_ready === 1'b1) break;
        end
        if (n == 1000) timed_out("command");
        cmd_valid <= 1'b0;
        for (n = 0; n < 100 && busy !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 40000 && busy !== 1'b0; n++) @(posedge clk);
        if (n == 40000) timed_out("transfer");
        repeat (20) @(posedge clk);
    endtask

    initial begin
        logic ok;
        rst_n = 1'b0;
        ce = 1'b1;
        cmd_valid = 1'b0;
        cmd_rw = 1'b0;
        cmd_ptr = 8'h00;
        cmd_len = 5'h00;
        wr_data = 8'h00;
        wr_valid = 1'b0;
        own_addr = srm_pkg::TARGET_ADDR;
        saw_nack = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check({6'h00, scl_w, sda_w}, 8'h03, "idle lines");
        check({7'h00, busy}, 8'h00, "idle busy");
        $display("test reset done");
        foreach (rows[r]) begin
            n_start = 0;
            n_stop = 0;
            rd_q.delete();
            if (!rows[r].rw) for (int i = 0; i < rows[r].len; i++) push(rows[r].base + 8'(i), ok);
            do_cmd(rows[r].rw, rows[r].ptr, rows[r].len);
            for (int i = 0; i < rows[r].len; i++) begin
                if (rows[r].rw) check(rd_q[i], rows[r].base + 8'(i), "read byte");
                else check(u_tgt.mem[8'(rows[r].ptr + i)], rows[r].base + 8'(i), "stored");
            end
            check(8'(rd_q.size()), rows[r].rw ? 8'(rows[r].len) : 8'h00, "read count");
            check(8'(n_start), rows[r].rw ? 8'h02 : 8'h01, "starts");
            check(8'(n_stop), 8'h01, "stops");
            $display("test row %0d done", r);
        end
        // fill the fifo until it refuses, then drain it in one write
        k = 0;
        ok = 1'b1;
        while (ok && k < 20) begin
            push(8'h50 + 8'(k), ok);
            if (ok) k++;
        end
        check(8'(k), 8'(srm_pkg::FIFO_DEPTH), "fifo depth");
        do_cmd(srm_pkg::CMD_WRITE, 8'h40, 5'(k));
        for (int i = 0; i < k; i++) check(u_tgt.mem[8'h40 + i], 8'h50 + 8'(i), "burst");
        $display("test fifo done");
        // target with another address must stay silent
        own_addr <= 7'h2d;
        saw_nack = 1'b0;
        rd_q.delete();
        do_cmd(srm_pkg::CMD_READ, 8'h10, 5'h01);
        check({7'h00, saw_nack}, 8'h01, "nack seen");
        check(8'(rd_q.size()), 8'h00, "no data after nack");
        own_addr <= srm_pkg::TARGET_ADDR;
        do_cmd(srm_pkg::CMD_READ, 8'h11, 5'h01);
        check(rd_q[0], 8'ha6, "read after nack");
        check({6'h00, scl_w, sda_w}, 8'h03, "released lines");
        $display("test nack done");
        report_and_stop();
    end
endmodule
